// ### logic/erb_embedded_ram_block.sv
// Embedded RAM block: RAM, ROM/lookup_table, dual-port RAM or FIFO
`timescale 1ns/100ps

// What this block does
// - Holds 4096 bits of storage when WIDTH divides 4096
// - Acts as RAM, ROM, dual-port or FIFO
// - Inputs and read data pass through registers
// - ROM contents loaded from fixed image
// - Lookup table: eight inputs, sixteen outputs
// - Data words up to sixteen bits wide
// - Single-port or dual-port selectable
// - Read and write sections run independently
// - Each section has own synchronous clock enable
// - Dual-port section serves as FIFO
module erb_embedded_ram_block
    import erb_pkg::*;
#(
    parameter int unsigned            WIDTH      = ERB_MAX_WIDTH,
    parameter logic [ERB_TOTAL_BITS-1:0] INIT_IMAGE = '0
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 srst,
    // Mode, caught while srst is high
    input  wire erb_mode_type         mode_sel,
    // Write section
    input  wire logic                 wr_clk_ena,
    input  wire logic                 wr_en,
    input  wire logic [$clog2(ERB_TOTAL_BITS/WIDTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]     wr_data,
    // Read section
    input  wire logic                 rd_clk_ena,
    input  wire logic                 rd_en,
    input  wire logic [$clog2(ERB_TOTAL_BITS/WIDTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]     rd_data,
    output logic                      rd_valid,
    // FIFO status
    output logic                      fifo_full,
    output logic                      fifo_empty
);
    localparam int unsigned DEPTH = ERB_TOTAL_BITS / WIDTH;
    localparam int unsigned AW    = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
    localparam logic [AW:0] ONE_CNT   = (AW+1)'(1);
    localparam logic [AW-1:0] ONE_PTR = AW'(1);

    // Reset values of the status outputs
    localparam logic EMPTY_RST = 1'b1;
    localparam logic FULL_RST  = 1'b0;

    typedef struct packed {
        // Storage and the mode caught at reset
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        erb_mode_type                mode;

        // Write section input registers
        logic                        w_act;
        logic                        w_en;
        logic [AW-1:0]               w_addr;
        logic [WIDTH-1:0]            w_data;

        // Read section input registers
        logic                        r_act;
        logic                        r_en;
        logic [AW-1:0]               r_addr;

        // FIFO pointers and fill level
        logic [AW-1:0]               wptr;
        logic [AW-1:0]               rptr;
        logic [AW:0]                 count;

        // Registered outputs
        logic [WIDTH-1:0]            rdata;
        logic                        rvalid;
        logic                        full;
        logic                        empty;
    } erb_state_type;

    erb_state_type state_q;
    erb_state_type state_d;

    // Next state of every register in the block
    always_comb begin
        logic          do_wr;
        logic          do_rd;
        logic [AW-1:0] wa;
        logic [AW-1:0] ra;
        logic [AW:0]   cnt;

        // Defaults: no access, addresses from the input registers
        do_wr   = 1'b0;
        do_rd   = 1'b0;
        wa      = state_q.w_addr;
        ra      = state_q.r_addr;
        cnt     = state_q.count;
        state_d = state_q;

        // Write section inputs, held while disabled
        state_d.w_act = wr_clk_ena;
        if (wr_clk_ena) begin
            state_d.w_en   = wr_en;
            state_d.w_addr = wr_addr;
            state_d.w_data = wr_data;
        end

        // Read section inputs, held while disabled
        state_d.r_act = rd_clk_ena;
        if (rd_clk_ena) begin
            state_d.r_en   = rd_en;
            state_d.r_addr = rd_addr;
        end

        // Read strobe lasts one cycle
        state_d.rvalid = 1'b0;

        // Access decode per mode
        case (state_q.mode)
            ERB_MODE_RAM: begin
                // One port: write enable picks write or read
                do_wr = state_q.w_act && state_q.w_en;
                do_rd = state_q.w_act && !state_q.w_en;
                ra    = state_q.w_addr;
            end

            ERB_MODE_ROM: begin
                // Lookup table: address in, stored word out
                do_wr = 1'b0;
                do_rd = state_q.r_act && state_q.r_en;
            end

            ERB_MODE_DUAL: begin
                // Sections act on their own enables
                do_wr = state_q.w_act && state_q.w_en;
                do_rd = state_q.r_act && state_q.r_en;
            end

            ERB_MODE_FIFO: begin
                // Pointers address the store; flags gate access
                do_wr = state_q.w_act && state_q.w_en
                        && !state_q.full;
                do_rd = state_q.r_act && state_q.r_en
                        && !state_q.empty;
                wa    = state_q.wptr;
                ra    = state_q.rptr;
                if (do_wr) begin
                    state_d.wptr = state_q.wptr + ONE_PTR;
                end
                if (do_rd) begin
                    state_d.rptr = state_q.rptr + ONE_PTR;
                end
                // Push and pop together leave the level unchanged
                case ({do_wr, do_rd})
                    2'h2: begin
                        cnt = state_q.count + ONE_CNT;
                    end
                    2'h1: begin
                        cnt = state_q.count - ONE_CNT;
                    end
                    default: begin
                        cnt = state_q.count;
                    end
                endcase
            end

            default: begin
                do_wr = 1'b0;
                do_rd = 1'b0;
            end
        endcase

        // Fill level and its flags
        state_d.count = cnt;
        state_d.full  = (cnt == DEPTH_CNT);
        state_d.empty = (cnt == '0);

        // Read port, old data on a shared address
        if (do_rd) begin
            state_d.rdata  = state_q.mem[ra];
            state_d.rvalid = 1'b1;
        end

        // Write port
        if (do_wr) begin
            state_d.mem[wa] = state_q.w_data;
        end
    end

    // State register; reset loads the image and the mode
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q.mem    <= INIT_IMAGE;
            state_q.mode   <= mode_sel;
            state_q.w_act  <= 1'b0;
            state_q.w_en   <= 1'b0;
            state_q.w_addr <= '0;
            state_q.w_data <= '0;
            state_q.r_act  <= 1'b0;
            state_q.r_en   <= 1'b0;
            state_q.r_addr <= '0;
            state_q.wptr   <= '0;
            state_q.rptr   <= '0;
            state_q.count  <= '0;
            state_q.rdata  <= '0;
            state_q.rvalid <= 1'b0;
            state_q.full   <= FULL_RST;
            state_q.empty  <= EMPTY_RST;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs straight from the state register
    assign rd_data    = state_q.rdata;
    assign rd_valid   = state_q.rvalid;
    assign fifo_full  = state_q.full;
    assign fifo_empty = state_q.empty;
endmodule

// ### logic/erb_pkg.sv
// Shared constants and mode encoding for the embedded RAM block
package erb_pkg;
    localparam int unsigned ERB_TOTAL_BITS = 4096;
    localparam int unsigned ERB_MAX_WIDTH  = 16;
    localparam int unsigned ERB_LUT_INPUTS = 8;

    typedef enum logic [1:0] {
        ERB_MODE_RAM,
        ERB_MODE_ROM,
        ERB_MODE_DUAL,
        ERB_MODE_FIFO
    } erb_mode_type;
endpackage

// ### bench/erb_sva.sv
// Port checker for the RAM block
`timescale 1ns/100ps
module erb_sva import erb_pkg::*; #(parameter int unsigned WIDTH = 16) (
    input wire logic clk, srst, wr_clk_ena, wr_en, rd_clk_ena, rd_en,
    input wire logic rd_valid, fifo_full, fifo_empty,
    input wire erb_mode_type mode_sel,
    input wire logic [WIDTH-1:0] rd_data
);
    erb_mode_type m_q;
    wire idle = wr_clk_ena && !wr_en && rd_clk_ena && !rd_en;
    always_ff @(posedge clk) if (srst) m_q <= mode_sel;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_reset_clear: assert property (disable iff (1'b0) srst |=>
        !rd_valid && fifo_empty && !fifo_full && rd_data == '0) else $error("rst");
    a_flags_apart: assert property (!(fifo_full && fifo_empty))
        else $error("flags");
    a_data_hold: assert property (!rd_valid |-> $stable(rd_data))
        else $error("hold");
    a_read_due: assert property ((m_q == ERB_MODE_ROM ||
        m_q == ERB_MODE_DUAL) && rd_clk_ena && rd_en ##1 rd_clk_ena |=> rd_valid)
        else $error("read");
    a_ram_read: assert property (m_q == ERB_MODE_RAM && wr_clk_ena &&
        !wr_en ##1 wr_clk_ena |=> rd_valid) else $error("ram");
    a_no_stray: assert property (m_q != ERB_MODE_RAM && rd_valid |->
        $past(rd_en, 2) && $past(rd_clk_ena, 2)) else $error("stray");
    a_push_fill: assert property (m_q == ERB_MODE_FIFO && wr_clk_ena &&
        wr_en && fifo_empty |-> ##2 !fifo_empty) else $error("push");
    a_idle_flag: assert property (idle [*2] |=> $stable(fifo_empty) &&
        $stable(fifo_full)) else $error("idle");
endmodule
bind erb_embedded_ram_block erb_sva #(.WIDTH(WIDTH)) u_erb_sva (
    .clk(clk), .srst(srst), .wr_clk_ena(wr_clk_ena), .wr_en(wr_en),
    .rd_clk_ena(rd_clk_ena), .rd_en(rd_en), .rd_valid(rd_valid),
    .fifo_full(fifo_full), .fifo_empty(fifo_empty),
    .mode_sel(mode_sel), .rd_data(rd_data));

// ### bench/erb_user.sv
// User logic model driving the RAM block
`timescale 1ns/100ps
module erb_user (
    input  wire logic  clk,
    output logic       wr_clk_ena, wr_en, rd_clk_ena, rd_en,
    output logic [7:0] wr_addr, rd_addr,
    output logic [15:0] wr_data
);
    initial {wr_clk_ena, rd_clk_ena, wr_en, rd_en, wr_addr, rd_addr} = 20'hc0000;
    initial wr_data = '0;
    task automatic xfer(input logic w, r, e, input logic [7:0] a,
                        input logic [15:0] d);
        @(negedge clk);
        {wr_clk_ena, rd_clk_ena, wr_en, rd_en} = {e, e, w, r};
        {wr_addr, rd_addr, wr_data} = {a, a, d};
        @(negedge clk);
        {wr_clk_ena, rd_clk_ena, wr_en, rd_en, wr_data} = {4'hc, ~d};
    endtask
endmodule

// ### bench/erb_embedded_ram_block_test.sv
// Self-checking bench for the RAM block
`timescale 1ns/100ps
module erb_embedded_ram_block_test;
    import erb_pkg::*;
    localparam logic [4095:0] IMG = {16'ha5c3, 4064'h0, 16'h1234};
    logic clk = 0, srst = 1, wr_clk_ena, wr_en, rd_clk_ena, rd_en;
    logic rd_valid, fifo_full, fifo_empty;
    logic [7:0] wr_addr, rd_addr;
    logic [15:0] wr_data, rd_data;
    erb_mode_type mode_sel = ERB_MODE_RAM;
    int error_cnt = 0, cmp_count = 0;
    erb_embedded_ram_block #(.WIDTH(16), .INIT_IMAGE(IMG))
        u_erb_embedded_ram_block (
        .clk(clk), .srst(srst), .mode_sel(mode_sel),
        .wr_clk_ena(wr_clk_ena), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_clk_ena(rd_clk_ena), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .fifo_full(fifo_full), .fifo_empty(fifo_empty));
    erb_user u_erb_user (
        .clk(clk), .wr_clk_ena(wr_clk_ena), .wr_en(wr_en),
        .rd_clk_ena(rd_clk_ena), .rd_en(rd_en), .wr_addr(wr_addr),
        .rd_addr(rd_addr), .wr_data(wr_data));
    initial forever #50 clk = ~clk;
    task automatic chk(input logic [16:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic boot(input erb_mode_type m);
        @(negedge clk);
        {srst, mode_sel} = {1'b1, m};
        repeat (4) @(negedge clk);
        srst = 0;
    endtask
    task automatic op(input logic w, r, e, input logic [7:0] a,
                      input logic [15:0] d, input logic [16:0] exp);
        u_erb_user.xfer(w, r, e, a, d);
        @(posedge clk);
        #1 chk({rd_valid, rd_data}, exp);
    endtask
    task automatic t_fifo;
        boot(ERB_MODE_FIFO);
        chk({fifo_full, fifo_empty}, 17'h1);
        for (int i = 0; i < 256; i++) op(1, 0, 1, 0, 16'(i), 17'h0);
        chk({fifo_full, fifo_empty}, 17'h2);
        op(1, 0, 1, 0, 16'hffff, 17'h0);
        for (int i = 0; i < 256; i++) op(0, 1, 1, 0, 0, {1'b1, 16'(i)});
        chk({fifo_full, fifo_empty}, 17'h1);
    endtask
    task automatic t_ram;
        boot(ERB_MODE_RAM);
        op(1, 0, 1, 8'h03, 16'h5a5a, 17'h01234);
        op(0, 0, 1, 8'h03, 16'h0, 17'h15a5a);
    endtask
    task automatic t_dual;
        boot(ERB_MODE_DUAL);
        op(1, 0, 1, 8'h05, 16'hbeef, 17'h0);
        op(0, 1, 1, 8'h05, 16'h0, 17'h1beef);
        op(1, 1, 0, 8'h05, 16'h0bad, 17'h0beef);
        op(0, 1, 1, 8'h05, 16'h0, 17'h1beef);
    endtask
    task automatic t_rom;
        boot(ERB_MODE_ROM);
        op(1, 0, 1, 8'h00, 16'hffff, 17'h0);
        op(0, 1, 1, 8'h00, 16'h0, 17'h11234);
        op(0, 1, 1, 8'hff, 16'h0, 17'h1a5c3);
    endtask
    task automatic close_out;
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #1000000 error_cnt++;
        close_out;
    end
    initial begin
        t_ram;
        t_dual;
        t_rom;
        t_fifo;
        close_out;
    end
endmodule
